// *** include/tcf_pkg.sv ***
// ****************************************
// timer constants
// ****************************************
package tcf_pkg;

  // waveform mode codes
  localparam logic [3:0]  MODE_NORMAL    = 4'h0;
  localparam logic [3:0]  MODE_CTC_CMP   = 4'h4;
  localparam logic [3:0]  MODE_FPWM_8    = 4'h5;
  localparam logic [3:0]  MODE_FPWM_9    = 4'h6;
  localparam logic [3:0]  MODE_FPWM_10   = 4'h7;
  localparam logic [3:0]  MODE_CTC_CAP   = 4'hc;
  localparam logic [3:0]  MODE_FPWM_CAP  = 4'he;
  localparam logic [3:0]  MODE_FPWM_CMP  = 4'hf;

  // fixed top values
  localparam logic [15:0] TOP_8BIT       = 16'h00ff;
  localparam logic [15:0] TOP_9BIT       = 16'h01ff;
  localparam logic [15:0] TOP_10BIT      = 16'h03ff;
  localparam logic [15:0] COUNT_MAX      = 16'hffff;
  localparam logic [15:0] COUNT_BOTTOM   = 16'h0000;

  // compare output actions
  localparam logic [1:0]  ACT_NONE       = 2'h0;
  localparam logic [1:0]  ACT_TOGGLE     = 2'h1;
  localparam logic [1:0]  ACT_CLEAR      = 2'h2;
  localparam logic [1:0]  ACT_SET        = 2'h3;

  // prescaler selections and divisors
  localparam logic [2:0]  PRE_STOP       = 3'h0;
  localparam logic [2:0]  PRE_DIV1       = 3'h1;
  localparam logic [2:0]  PRE_DIV8       = 3'h2;
  localparam logic [2:0]  PRE_DIV64      = 3'h3;
  localparam logic [2:0]  PRE_DIV256     = 3'h4;
  localparam logic [2:0]  PRE_DIV1024    = 3'h5;
  localparam logic [9:0]  DIV1_LAST      = 10'h000;
  localparam logic [9:0]  DIV8_LAST      = 10'h007;
  localparam logic [9:0]  DIV64_LAST     = 10'h03f;
  localparam logic [9:0]  DIV256_LAST    = 10'h0ff;
  localparam logic [9:0]  DIV1024_LAST   = 10'h3ff;

  // reset values
  localparam logic [15:0] RST_COUNT      = 16'h0000;
  localparam logic [15:0] RST_COMPARE    = 16'h0000;
  localparam logic [9:0]  RST_PRESCALE   = 10'h000;

endpackage : tcf_pkg

// *** hw/tcf_compare_unit.sv ***
`timescale 1ns/10ps
// ****************************************
// one compare channel
// ****************************************
module tcf_compare_unit
  import tcf_pkg::*;
#(
  parameter int W = 16
)
(
  // clock and reset
  input  wire logic         clock,
  input  wire logic         rst,
  // timer state
  input  wire logic         tick,
  input  wire logic [W-1:0] counter_value,
  input  wire logic         fast_pwm,
  input  wire logic         at_top,
  input  wire logic         toggle_ok,
  // configuration
  input  wire logic [1:0]   compare_output_action,
  input  wire logic [W-1:0] write_mask,
  input  wire logic         compare_wr,
  input  wire logic [W-1:0] wr_data,
  input  wire logic         flag_clr,
  // results
  output logic [W-1:0]      compare_value,
  output logic [W-1:0]      buffer_value,
  output logic              match,
  output logic              compare_flag,
  output logic              compare_state
);

  logic [W-1:0] active_r;
  logic [W-1:0] buffer_r;
  logic         flag_r;
  logic         state_r;
  logic         state_nxt;

  assign compare_value = active_r;
  assign buffer_value  = buffer_r;
  assign compare_flag  = flag_r;
  assign compare_state = state_r;
  assign match         = (counter_value == active_r);

  // buffer catches writes, masked to the fixed resolution
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      buffer_r <= RST_COMPARE;
    else if (compare_wr)
      buffer_r <= wr_data & write_mask;
  end

  // active value: direct outside fast pwm, loaded at top inside it
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      active_r <= RST_COMPARE;
    else if (compare_wr && !fast_pwm)
      active_r <= wr_data & write_mask;
    else if (fast_pwm && tick && at_top)
      active_r <= buffer_r;
  end

  // match flag; a set in the clearing cycle wins
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      flag_r <= 1'b0;
    else if (tick && match)
      flag_r <= 1'b1;
    else if (flag_clr)
      flag_r <= 1'b0;
  end

  // output state; action is read live so a new setting acts at the next match
  always_comb
  begin
    state_nxt = state_r;
    if (tick && fast_pwm)
    begin
      if (at_top && compare_output_action == ACT_CLEAR)
        state_nxt = 1'b0;
      if (at_top && compare_output_action == ACT_SET)
        state_nxt = 1'b1;
      // match applied last so a value equal to top gives a steady level
      if (match)
      begin
        unique case (compare_output_action)
          ACT_NONE:   state_nxt = state_r;
          ACT_TOGGLE: state_nxt = toggle_ok ? !state_r : state_r;
          ACT_CLEAR:  state_nxt = 1'b1;
          ACT_SET:    state_nxt = 1'b0;
        endcase
      end
    end
    else if (tick && match)
    begin
      unique case (compare_output_action)
        ACT_NONE:   state_nxt = state_r;
        ACT_TOGGLE: state_nxt = !state_r;
        ACT_CLEAR:  state_nxt = 1'b0;
        ACT_SET:    state_nxt = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      state_r <= 1'b0;
    else
      state_r <= state_nxt;
  end

  // ****************************************
  // checks
  // ****************************************
  mask_write_a: assert property (@(posedge clock) disable iff (rst)
    compare_wr |=> (buffer_r & ~$past(write_mask)) == '0)
    else $error("compare buffer kept bits above resolution");
  ctc_toggle_a: assert property (@(posedge clock) disable iff (rst)
    tick && match && !fast_pwm && compare_output_action == ACT_TOGGLE |=> state_r != $past(state_r))
    else $error("toggle did not invert output");
  pwm_set_a: assert property (@(posedge clock) disable iff (rst)
    tick && match && fast_pwm && compare_output_action == ACT_CLEAR |=> state_r)
    else $error("non-inverted pwm not set on match");
  buffer_load_a: assert property (@(posedge clock) disable iff (rst)
    fast_pwm && tick && at_top && !compare_wr |=> active_r == $past(buffer_r))
    else $error("active compare not loaded at top");
  match_flag_a: assert property (@(posedge clock) disable iff (rst)
    tick && match |=> flag_r)
    else $error("compare flag missed");
  action_none_a: assert property (@(posedge clock) disable iff (rst)
    compare_output_action == ACT_NONE && !(fast_pwm && at_top) |=> $stable(state_r))
    else $error("output moved with no action");

endmodule : tcf_compare_unit

// *** hw/tcf_timer.sv ***
`timescale 1ns/10ps
module tcf_timer
  import tcf_pkg::*;
#(
  parameter int W = 16
)
(
  // clock and reset
  input  wire logic         clock,
  input  wire logic         rst,
  // configuration
  input  wire logic [3:0]   waveform_mode_select,
  input  wire logic [2:0]   clock_select,
  input  wire logic [1:0]   compare_a_output_action,
  input  wire logic [1:0]   compare_b_output_action,
  // register writes
  input  wire logic [W-1:0] wr_data,
  input  wire logic         compare_a_wr,
  input  wire logic         compare_b_wr,
  input  wire logic         capture_top_wr,
  // flag clears
  input  wire logic         overflow_flag_clr,
  input  wire logic         compare_a_flag_clr,
  input  wire logic         compare_b_flag_clr,
  input  wire logic         capture_flag_clr,
  // port control
  input  wire logic         pin_direction_a,
  input  wire logic         pin_direction_b,
  input  wire logic         port_data_a,
  input  wire logic         port_data_b,
  // status
  output logic [W-1:0]      counter_value,
  output logic [W-1:0]      compare_a_value,
  output logic [W-1:0]      compare_b_value,
  output logic [W-1:0]      capture_top_value,
  output logic              overflow_flag,
  output logic              compare_a_flag,
  output logic              compare_b_flag,
  output logic              capture_flag,
  // pins
  output logic              compare_a_pin,
  output logic              compare_a_pin_oe,
  output logic              compare_b_pin,
  output logic              compare_b_pin_oe
);

  // ****************************************
  // prescaler
  // ****************************************
  logic [9:0]   pre_r;
  logic [9:0]   pre_last;
  logic         tick;

  // divisor choice; a stopped prescaler never ticks
  always_comb
  begin
    unique case (clock_select)
      PRE_DIV1:    pre_last = DIV1_LAST;
      PRE_DIV8:    pre_last = DIV8_LAST;
      PRE_DIV64:   pre_last = DIV64_LAST;
      PRE_DIV256:  pre_last = DIV256_LAST;
      PRE_DIV1024: pre_last = DIV1024_LAST;
      default:     pre_last = DIV1_LAST;
    endcase
  end

  assign tick = (clock_select != PRE_STOP) && (clock_select <= PRE_DIV1024)
                && (pre_r >= pre_last);

  // reaching past the last count also ticks, so a divisor change never stalls
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      pre_r <= RST_PRESCALE;
    else if (tick || clock_select == PRE_STOP)
      pre_r <= RST_PRESCALE;
    else
      pre_r <= pre_r + 10'h001;
  end

  // ****************************************
  // mode decode and top selection
  // ****************************************
  logic         ctc_mode;
  logic         fast_pwm;
  logic         fixed_top;
  logic [W-1:0] top_value;
  logic [W-1:0] write_mask;
  logic         at_top;
  logic         match_a;
  logic         match_b;

  assign ctc_mode  = (waveform_mode_select == MODE_CTC_CMP) || (waveform_mode_select == MODE_CTC_CAP);
  assign fast_pwm  = (waveform_mode_select == MODE_FPWM_8) || (waveform_mode_select == MODE_FPWM_9)
                  || (waveform_mode_select == MODE_FPWM_10) || (waveform_mode_select == MODE_FPWM_CAP)
                  || (waveform_mode_select == MODE_FPWM_CMP);
  assign fixed_top = (waveform_mode_select == MODE_FPWM_8) || (waveform_mode_select == MODE_FPWM_9)
                  || (waveform_mode_select == MODE_FPWM_10);

  // top source per mode; normal and unsupported modes run to the full range
  always_comb
  begin
    unique case (waveform_mode_select)
      MODE_CTC_CMP:  top_value = compare_a_value;
      MODE_CTC_CAP:  top_value = capture_top_value;
      MODE_FPWM_8:   top_value = TOP_8BIT;
      MODE_FPWM_9:   top_value = TOP_9BIT;
      MODE_FPWM_10:  top_value = TOP_10BIT;
      MODE_FPWM_CAP: top_value = capture_top_value;
      MODE_FPWM_CMP: top_value = compare_a_value;
      default:       top_value = COUNT_MAX;
    endcase
  end

  // compare writes lose bits above a fixed top's resolution
  assign write_mask = fixed_top ? top_value : COUNT_MAX;

  // equality only: a top already passed is missed until the counter wraps
  assign at_top = (ctc_mode || fast_pwm) && (counter_value == top_value);

  // ****************************************
  // counter
  // ****************************************
  logic [W-1:0] count_r;

  assign counter_value = count_r;

  // clears on the tick after it stands at top, otherwise climbs and wraps
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      count_r <= RST_COUNT;
    else if (tick && at_top)
      count_r <= COUNT_BOTTOM;
    else if (tick)
      count_r <= count_r + W'(1);
  end

  // ****************************************
  // capture register used as top
  // ****************************************
  logic [W-1:0] capture_r;

  assign capture_top_value = capture_r;

  // no buffering here, so a late lower value costs a full wrap
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      capture_r <= RST_COMPARE;
    else if (capture_top_wr)
      capture_r <= wr_data;
  end

  // ****************************************
  // flags
  // ****************************************
  logic         overflow_r;
  logic         capture_flag_r;
  logic         cap_is_top;

  assign overflow_flag = overflow_r;
  assign capture_flag  = capture_flag_r;
  assign cap_is_top    = (waveform_mode_select == MODE_CTC_CAP) || (waveform_mode_select == MODE_FPWM_CAP);

  // overflow at top in fast pwm, at the full-range wrap otherwise; set wins
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      overflow_r <= 1'b0;
    else if (tick && fast_pwm && at_top)
      overflow_r <= 1'b1;
    else if (tick && !fast_pwm && count_r == COUNT_MAX)
      overflow_r <= 1'b1;
    else if (overflow_flag_clr)
      overflow_r <= 1'b0;
  end

  // capture flag marks top when the capture register defines it
  always_ff @(posedge clock or posedge rst)
  begin
    if (rst)
      capture_flag_r <= 1'b0;
    else if (tick && cap_is_top && at_top)
      capture_flag_r <= 1'b1;
    else if (capture_flag_clr)
      capture_flag_r <= 1'b0;
  end

  // ****************************************
  // compare channels
  // ****************************************
  logic         state_a;
  logic         state_b;

  // channel a defines top in modes 4 and 15, so its flag marks top there
  tcf_compare_unit #(.W(W)) u_cmp_a (
    .clock                 (clock),
    .rst                   (rst),
    .tick                  (tick),
    .counter_value         (count_r),
    .fast_pwm              (fast_pwm),
    .at_top                (at_top),
    .toggle_ok             (waveform_mode_select == MODE_FPWM_CMP),
    .compare_output_action (compare_a_output_action),
    .write_mask            (write_mask),
    .compare_wr            (compare_a_wr),
    .wr_data               (wr_data),
    .flag_clr              (compare_a_flag_clr),
    .compare_value         (compare_a_value),
    .buffer_value          (),
    .match                 (match_a),
    .compare_flag          (compare_a_flag),
    .compare_state         (state_a)
  );

  tcf_compare_unit #(.W(W)) u_cmp_b (
    .clock                 (clock),
    .rst                   (rst),
    .tick                  (tick),
    .counter_value         (count_r),
    .fast_pwm              (fast_pwm),
    .at_top                (at_top),
    .toggle_ok             (1'b0),
    .compare_output_action (compare_b_output_action),
    .write_mask            (write_mask),
    .compare_wr            (compare_b_wr),
    .wr_data               (wr_data),
    .flag_clr              (compare_b_flag_clr),
    .compare_value         (compare_b_value),
    .buffer_value          (),
    .match                 (match_b),
    .compare_flag          (compare_b_flag),
    .compare_state         (state_b)
  );

  // ****************************************
  // pin override
  // ****************************************
  // compare state replaces the port data whenever an action is set; the enable follows the direction bit alone
  assign compare_a_pin    = (compare_a_output_action != ACT_NONE) ? state_a : port_data_a;
  assign compare_a_pin_oe = pin_direction_a;
  assign compare_b_pin    = (compare_b_output_action != ACT_NONE) ? state_b : port_data_b;
  assign compare_b_pin_oe = pin_direction_b;

  // ****************************************
  // checks
  // ****************************************
  ctc_clear_a: assert property (@(posedge clock) disable iff (rst)
    tick && ctc_mode && count_r == top_value |=> count_r == COUNT_BOTTOM)
    else $error("counter not cleared at top");
  ctc_wrap_a: assert property (@(posedge clock) disable iff (rst)
    tick && ctc_mode && count_r == COUNT_MAX
    |=> count_r == COUNT_BOTTOM && overflow_r)
    else $error("wrap did not set overflow");
  pwm_top_a: assert property (@(posedge clock) disable iff (rst)
    tick && fast_pwm && at_top |=> count_r == COUNT_BOTTOM && overflow_r)
    else $error("fast pwm top handling wrong");
  cap_flag_a: assert property (@(posedge clock) disable iff (rst)
    tick && cap_is_top && count_r == capture_r |=> capture_flag_r)
    else $error("capture flag missed at top");
  hold_count_a: assert property (@(posedge clock) disable iff (rst)
    !tick |=> count_r == $past(count_r))
    else $error("counter moved without tick");
  div8_tick_a: assert property (@(posedge clock) disable iff (rst)
    tick && clock_select == PRE_DIV8 ##1 clock_select == PRE_DIV8 [*8] |-> tick && !$past(tick))
    else $error("divide by eight ticked early");
  pin_drive_a: assert property (@(posedge clock) disable iff (rst)
    compare_a_output_action != ACT_NONE |-> compare_a_pin == state_a && compare_a_pin_oe == pin_direction_a)
    else $error("pin does not show compare state");
  step_up_a: assert property (@(posedge clock) disable iff (rst)
    tick && fast_pwm && !at_top |=> count_r == $past(count_r) + 16'h0001)
    else $error("fast pwm count did not step up");

endmodule : tcf_timer

// *** verification/tb.sv ***
`timescale 1ns/10ps
// ****************************************
// timer bench
// ****************************************
module tb
  import tcf_pkg::*;
;
  // design inputs
  logic        clock = 1'b0;
  logic        rst;
  logic [3:0]  waveform_mode_select;
  logic [2:0]  clock_select;
  logic [1:0]  compare_a_output_action, compare_b_output_action;
  logic [15:0] wr_data;
  logic        compare_a_wr, compare_b_wr, capture_top_wr;
  logic        overflow_flag_clr, compare_a_flag_clr, compare_b_flag_clr, capture_flag_clr;
  logic        pin_direction_a, pin_direction_b, port_data_a, port_data_b;
  // design outputs
  logic [15:0] counter_value, compare_a_value, compare_b_value, capture_top_value;
  logic        overflow_flag, compare_a_flag, compare_b_flag, capture_flag;
  logic        compare_a_pin, compare_a_pin_oe, compare_b_pin, compare_b_pin_oe;
  // reference state, one edge ahead of the outputs
  logic [15:0] m_cnt, m_ca, m_cb, m_ba, m_bb, m_cap;
  logic        m_ovf, m_fa, m_fb, m_fc, m_sa, m_sb;
  logic        model_on, wa_ok, wc_ok, saw_max;
  logic [31:0] r;
  int          fails = 0;
  int          cmp_count = 0;
  int          seed = 62978;
  int          i;
  logic [3:0]  modes [7] = '{MODE_CTC_CMP, MODE_CTC_CAP, MODE_FPWM_8, MODE_FPWM_9,
                             MODE_FPWM_10, MODE_FPWM_CAP, MODE_FPWM_CMP};

  // 25 MHz clock
  always #20 clock = ~clock;

  tcf_timer #(.W(16)) i_dut
  (
    .clock, .rst, .waveform_mode_select, .clock_select, .compare_a_output_action,
    .compare_b_output_action, .wr_data, .compare_a_wr, .compare_b_wr, .capture_top_wr,
    .overflow_flag_clr, .compare_a_flag_clr, .compare_b_flag_clr, .capture_flag_clr,
    .pin_direction_a, .pin_direction_b, .port_data_a, .port_data_b,
    .counter_value, .compare_a_value, .compare_b_value, .capture_top_value,
    .overflow_flag, .compare_a_flag, .compare_b_flag, .capture_flag,
    .compare_a_pin, .compare_a_pin_oe, .compare_b_pin, .compare_b_pin_oe
  );

  // ****************************************
  // reference functions
  // ****************************************
  function automatic logic [15:0] top_of(input logic [3:0] md);
    case (md)
      MODE_CTC_CMP, MODE_FPWM_CMP: return m_ca;
      MODE_CTC_CAP, MODE_FPWM_CAP: return m_cap;
      MODE_FPWM_8:                 return TOP_8BIT;
      MODE_FPWM_9:                 return TOP_9BIT;
      default:                     return TOP_10BIT;
    endcase
  endfunction : top_of

  // write mask follows the fixed resolution only
  function automatic logic [15:0] mask_of(input logic [3:0] md);
    case (md)
      MODE_FPWM_8:  return TOP_8BIT;
      MODE_FPWM_9:  return TOP_9BIT;
      MODE_FPWM_10: return TOP_10BIT;
      default:      return COUNT_MAX;
    endcase
  endfunction : mask_of

  // bottom action first, match last, so compare equal to top holds a level
  function automatic logic nxt_state(input logic [1:0] act, input logic st, input logic fp,
                                     input logic tp, input logic m, input logic tog);
    logic s;
    s = st;
    if (fp && tp && act != ACT_NONE && act != ACT_TOGGLE)
      s = (act == ACT_SET);
    if (m && act == ACT_TOGGLE && (tog || !fp))
      s = ~s;
    if (m && act == ACT_CLEAR)
      s = fp;
    if (m && act == ACT_SET)
      s = !fp;
    return s;
  endfunction : nxt_state

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one tick of the reference, all from pre-edge values
  task automatic model_step;
    logic        fp, tp, ma, mb;
    logic [15:0] msk;
    fp    = waveform_mode_select inside {MODE_FPWM_8, MODE_FPWM_9, MODE_FPWM_10, MODE_FPWM_CAP, MODE_FPWM_CMP};
    tp    = (m_cnt == top_of(waveform_mode_select));
    ma    = (m_cnt == m_ca);
    mb    = (m_cnt == m_cb);
    msk   = mask_of(waveform_mode_select);
    m_sa  = nxt_state(compare_a_output_action, m_sa, fp, tp, ma, waveform_mode_select == MODE_FPWM_CMP);
    m_sb  = nxt_state(compare_b_output_action, m_sb, fp, tp, mb, 1'b0);
    m_ovf = (fp ? tp : (m_cnt == COUNT_MAX)) | (m_ovf & ~overflow_flag_clr);
    m_fa  = ma | (m_fa & ~compare_a_flag_clr);
    m_fb  = mb | (m_fb & ~compare_b_flag_clr);
    m_fc  = (tp && waveform_mode_select inside {MODE_CTC_CAP, MODE_FPWM_CAP}) | (m_fc & ~capture_flag_clr);
    m_cnt = tp ? COUNT_BOTTOM : m_cnt + 16'h0001;
    if (fp && tp)
    begin
      m_ca = m_ba;
      m_cb = m_bb;
    end
    if (compare_a_wr)
    begin
      m_ba = wr_data & msk;
      m_ca = fp ? m_ca : (wr_data & msk);
    end
    if (compare_b_wr)
    begin
      m_bb = wr_data & msk;
      m_cb = fp ? m_cb : (wr_data & msk);
    end
    if (capture_top_wr)
      m_cap = wr_data;
  endtask : model_step

  // outputs checked at the edge, before the design's updates land
  always @(posedge clock or posedge rst)
  begin
    if (rst)
    begin
      {m_cnt, m_ca, m_cb, m_ba, m_bb, m_cap} = '0;
      {m_ovf, m_fa, m_fb, m_fc, m_sa, m_sb} = '0;
    end
    else
    begin
      if (model_on)
      begin
        chk(counter_value, m_cnt);
        chk(compare_a_value, m_ca);
        chk(compare_b_value, m_cb);
        chk(capture_top_value, m_cap);
        chk(overflow_flag, m_ovf);
        chk(compare_a_flag, m_fa);
        chk(compare_b_flag, m_fb);
        chk(capture_flag, m_fc);
        chk(compare_a_pin, (compare_a_output_action != ACT_NONE) ? m_sa : port_data_a);
        chk(compare_b_pin, (compare_b_output_action != ACT_NONE) ? m_sb : port_data_b);
        chk(compare_a_pin_oe, pin_direction_a);
        chk(compare_b_pin_oe, pin_direction_b);
      end
      if (counter_value === COUNT_MAX)
        saw_max = 1'b1;
      model_step;
    end
  end

  // ****************************************
  // drivers, all at the falling edge
  // ****************************************
  task automatic do_reset(input logic mon, input logic [3:0] md);
    rst = 1'b1;
    model_on = mon;
    {wa_ok, wc_ok, compare_a_wr, compare_b_wr, capture_top_wr} = '0;
    {overflow_flag_clr, compare_a_flag_clr, compare_b_flag_clr, capture_flag_clr} = '0;
    {pin_direction_a, pin_direction_b, port_data_a, port_data_b} = '0;
    {compare_a_output_action, compare_b_output_action, wr_data} = '0;
    waveform_mode_select = md;
    clock_select = PRE_DIV1;
    repeat (12) @(negedge clock);
    rst = 1'b0;
  endtask : do_reset

  task automatic drive_random;
    r = $random(seed);
    {overflow_flag_clr, compare_a_flag_clr} = {r[3:0] == 4'h0, r[7:4] == 4'h0};
    {compare_b_flag_clr, capture_flag_clr} = {r[11:8] == 4'h0, r[15:12] == 4'h0};
    {pin_direction_a, pin_direction_b, port_data_a, port_data_b} = r[19:16];
    if (r[25:20] == 6'h00)
      compare_a_output_action = r[27:26];
    if (r[25:20] == 6'h01)
      compare_b_output_action = r[29:28];
    r = $random(seed);
    compare_a_wr = wa_ok && r[4:0] == 5'h00;
    compare_b_wr = r[9:5] == 5'h00;
    capture_top_wr = wc_ok && r[14:10] == 5'h00;
    // programmable tops stay above their minimum and above every compare value
    if (mask_of(waveform_mode_select) != COUNT_MAX)
      wr_data = r[31:16];
    else if (compare_a_wr || capture_top_wr)
      wr_data = {11'h000, r[20:16]} + 16'h0010;
    else
      wr_data = {12'h000, r[19:16]};
  endtask : drive_random

  // reset, set up top and compares, then run at random
  task automatic seg(input logic [3:0] md, input int n, input logic wa, input logic wc,
                     input logic [15:0] ia, input logic [15:0] ib);
    do_reset(1'b1, md);
    r = $random(seed);
    {compare_a_output_action, compare_b_output_action} = r[3:0];
    {capture_top_wr, wr_data} = {1'b1, {11'h000, r[8:4]} + 16'h0030};
    @(negedge clock);
    {capture_top_wr, compare_a_wr, wr_data} = {2'b01, ia};
    @(negedge clock);
    {compare_a_wr, compare_b_wr, wr_data} = {2'b01, ib};
    @(negedge clock);
    {wa_ok, wc_ok, compare_b_wr} = {wa, wc, 1'b0};
    repeat (n) @(negedge clock) drive_random;
  endtask : seg

  // interval between toggles, prescaled, compare value three
  task automatic presc(input logic [2:0] sel, input int n);
    int  k;
    logic p;
    do_reset(1'b0, MODE_CTC_CMP);
    {clock_select, compare_a_output_action, compare_a_wr, wr_data} = {sel, ACT_TOGGLE, 1'b1, 16'h0003};
    @(negedge clock);
    compare_a_wr = 1'b0;
    repeat (3)
    begin
      k = 0;
      p = compare_a_pin;
      while (compare_a_pin === p && k < 10000)
      begin
        @(negedge clock);
        k++;
      end
    end
    chk(k[15:0], n[15:0] * 16'h0004);
  endtask : presc

  task automatic print_verdict;
    $display("comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict

  // ****************************************
  // sequence
  // ****************************************
  initial
  begin
    do_reset(1'b1, MODE_CTC_CMP);
    seg(MODE_FPWM_8, 1200, 1'b0, 1'b1, TOP_8BIT, COUNT_BOTTOM);
    seg(MODE_FPWM_CMP, 400, 1'b1, 1'b1, 16'h000f, 16'h0002);
    seg(MODE_CTC_CMP, 300, 1'b0, 1'b1, 16'h000f, 16'h0004);
    for (i = 0; i < 7; i++)
    begin
      r = $random(seed);
      seg(modes[i], (i inside {2, 3, 4}) ? 2200 : 400, modes[i] != MODE_CTC_CMP,
          !(modes[i] inside {MODE_CTC_CAP, MODE_FPWM_CAP}),
          (i inside {2, 3, 4}) ? (r[15:0] | 16'h0008) : ({12'h000, r[3:0]} + 16'h0010),
          (i inside {2, 3, 4}) ? r[31:16] : {12'h000, r[19:16]});
    end
    // top lowered under the count: wraps through the maximum
    seg(MODE_CTC_CAP, 0, 1'b0, 1'b0, 16'h0010, 16'h0001);
    i = 0;
    while (m_cnt != 16'h0020 && i < 100)
    begin
      @(negedge clock);
      i++;
    end
    {capture_top_wr, wr_data} = {1'b1, 16'h0010};
    saw_max = 1'b0;
    @(negedge clock);
    capture_top_wr = 1'b0;
    repeat (65600) @(negedge clock) drive_random;
    chk(saw_max, 1'b1);
    presc(PRE_DIV1, 1);
    presc(PRE_DIV8, 8);
    presc(PRE_DIV64, 64);
    presc(PRE_DIV256, 256);
    presc(PRE_DIV1024, 1024);
    print_verdict;
  end

  // watchdog at 100000 clocks, only a little past the expected length of the run
  initial
  begin
    #(40 * 100000);
    fails++;
    print_verdict;
  end

endmodule : tb
